// ---- rtl/iqm_params.svh ----
// Notes on behaviour
// - compensator bypass control bit skips inverse-CIC
// - CIC at 1x forces compensator bypass
// - bypassed compensator holds idle, registers frozen
// - compensator is FIR inverting CIC droop
// - compensator loss about 0.5/0.8 dB
// - fixed 4x stage: two 2x half-bands
// - two input words form one I/Q pair
// - half-bands symmetric, negligible insertion loss
// - half-band pass band flat to 80%
// - half-band stop band attenuates images
// - 6-bit per-profile CIC rate, 2 to 63
// - per-profile CIC bypass gives 1x, idles stage
// - CIC is fifth order boxcar cascade
// - modulator samples arrive every system clock
// - I times cosine, Q times sine, added or subtracted
// - spectral invert: 1 adds, 0 subtracts
// - interpolating DAC mode: I only, unmodulated
// - carrier from 32-bit per-profile tuning word
`ifndef IQM_PARAMS_SVH
`define IQM_PARAMS_SVH

`define IQM_IN_W 14
`define IQM_DW 16
`define IQM_SAT_W 40
`define IQM_CIC_ORDER 5
`define IQM_CIC_GROW 24
`define IQM_RATE_W 6
`define IQM_RATE_MIN 6'h02
`define IQM_ICIC_SH 5
`define IQM_ICIC_C_R2 34
`define IQM_ICIC_S_R2 2
`define IQM_ICIC_C_RN 37
`define IQM_ICIC_S_RN 4
`define IQM_HB_C1 9
`define IQM_HB_C0 1
`define IQM_HB_SH 4
`define IQM_FTW_W 32
`define IQM_PH_W 12
`define IQM_CAR_MAX 2047
`define IQM_MOD_SH 11

`endif

// ---- rtl/iqm_pkg.sv ----
`default_nettype none
`include "iqm_params.svh"

package iqm_pkg;

	typedef enum logic [1:0] {
		IQM_ASM_FLUSH = 2'b00,
		IQM_ASM_WANT_I = 2'b01,
		IQM_ASM_WANT_Q = 2'b10
	} iqm_asm_t;

	typedef logic signed [`IQM_DW-1:0] iqm_smp_t;

	// clamp a wide signed value into one internal sample
	function automatic iqm_smp_t iqm_sat(input logic signed [`IQM_SAT_W-1:0] v);
		logic signed [`IQM_SAT_W-1:0] hi;
		logic signed [`IQM_SAT_W-1:0] lo;
		hi = (`IQM_SAT_W'(1) <<< (`IQM_DW - 1)) - `IQM_SAT_W'(1);
		lo = -(`IQM_SAT_W'(1) <<< (`IQM_DW - 1));
		if (v > hi) begin
			return iqm_smp_t'(hi);
		end else if (v < lo) begin
			return iqm_smp_t'(lo);
		end
		return iqm_smp_t'(v);
	endfunction : iqm_sat

endpackage : iqm_pkg

`default_nettype wire

// ---- rtl/iqm_halfband.sv ----
`timescale 1ns/100ps
`default_nettype none

module iqm_halfband
	import iqm_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// rate strobes
	input wire logic inStb,
	input wire logic outStb,
	// samples
	input wire iqm_smp_t din,
	output iqm_smp_t dout
);

	iqm_smp_t tap [4];
	logic signed [`IQM_SAT_W-1:0] oddSum;

	//--------------------------------
	// delay line, advances at input rate
	//--------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int k = 0; k < 4; k++) begin
				tap[k] <= '0;
			end
		end else if (inStb) begin
			tap[0] <= din;
			for (int k = 1; k < 4; k++) begin
				tap[k] <= tap[k-1];
			end
		end
	end

	// odd polyphase of a symmetric 7-tap half-band
	always_comb begin
		oddSum = `IQM_SAT_W'(`IQM_HB_C1) *
			(`IQM_SAT_W'(tap[1]) + `IQM_SAT_W'(tap[2])) -
			`IQM_SAT_W'(`IQM_HB_C0) * (`IQM_SAT_W'(tap[0]) + `IQM_SAT_W'(tap[3]));
	end

	//--------------------------------
	// output: even phase is the centre tap, odd phase interpolated
	//--------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			dout <= '0;
		end else if (outStb) begin
			if (inStb) begin
				dout <= tap[1];
			end else begin
				dout <= iqm_sat(oddSum >>> `IQM_HB_SH);
			end
		end
	end

endmodule : iqm_halfband

`default_nettype wire

// ---- rtl/iqm_interp_mod.sv ----
`timescale 1ns/100ps
`default_nettype none

module iqm_interp_mod
	import iqm_pkg::*;
#(
	parameter int IN_W = `IQM_IN_W,
	parameter int RATE_W = `IQM_RATE_W,
	parameter int FTW_W = `IQM_FTW_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// baseband word input
	input wire logic [IN_W-1:0] dataWord,
	input wire logic txEnable,
	output logic wordReq,
	// mode and global control
	input wire logic interpDacMode,
	input wire logic invCicBypass,
	// profile set
	input wire logic [1:0] profileSel,
	input wire logic [3:0][RATE_W-1:0] profCicRate,
	input wire logic [3:0] profCicBypass,
	input wire logic [3:0] profSpecInvert,
	input wire logic [3:0][FTW_W-1:0] profFreqWord,
	// modulated output
	output logic [IN_W-1:0] modOut
);

	localparam int ACC_W = `IQM_DW + `IQM_CIC_GROW;

	//--------------------------------
	// helpers
	//--------------------------------
	function automatic logic [4:0] ceilLog2Rate(input logic [RATE_W-1:0] r);
		logic [4:0] n;
		n = '0;
		for (int b = 0; b < RATE_W; b++) begin
			if ((r - RATE_W'(1)) >> b != '0) begin
				n = 5'(b + 1);
			end
		end
		return n;
	endfunction : ceilLog2Rate

	// parabolic sine of a signed phase, full scale at a quarter turn
	function automatic logic signed [`IQM_PH_W-1:0] sineOf(input logic [`IQM_PH_W-1:0] ph);
		logic signed [`IQM_PH_W:0] x;
		logic signed [`IQM_PH_W:0] mag;
		logic signed [2*`IQM_PH_W+1:0] prod;
		x = `IQM_PH_W'(0) + (`IQM_PH_W+1)'(signed'(ph));
		mag = (x < 0) ? -x : x;
		prod = (2*`IQM_PH_W+2)'(x) * (2*`IQM_PH_W+2)'((`IQM_PH_W+1)'(1 << (`IQM_PH_W-1)) - mag);
		prod = prod >>> (`IQM_PH_W - 3);
		if (prod > (2*`IQM_PH_W+2)'(`IQM_CAR_MAX)) begin
			prod = (2*`IQM_PH_W+2)'(`IQM_CAR_MAX);
		end else if (prod < -(2*`IQM_PH_W+2)'(`IQM_CAR_MAX)) begin
			prod = -(2*`IQM_PH_W+2)'(`IQM_CAR_MAX);
		end
		return `IQM_PH_W'(prod);
	endfunction : sineOf

	//--------------------------------
	// profile decode
	//--------------------------------
	logic [RATE_W-1:0] effRate;
	logic cicOff;
	logic icicOff;
	logic specInv;
	logic [FTW_W-1:0] freqWord;
	logic [4:0] cicShift;

	always_comb begin
		cicOff = profCicBypass[profileSel];
		specInv = profSpecInvert[profileSel];
		freqWord = profFreqWord[profileSel];
		if (cicOff) begin
			effRate = RATE_W'(1);
		end else if (profCicRate[profileSel] < `IQM_RATE_MIN) begin
			effRate = `IQM_RATE_MIN;
		end else begin
			effRate = profCicRate[profileSel];
		end
		icicOff = invCicBypass || cicOff;
		cicShift = 5'(ceilLog2Rate(effRate) * 5'd4);
	end

	//--------------------------------
	// rate strobes
	//--------------------------------
	logic [RATE_W-1:0] rateCnt;
	logic [1:0] hbPhase;
	logic cicStb;
	logic hb1OutStb;
	logic pairStb;
	logic wordStb;
	logic [RATE_W-1:0] prevRate;
	logic cicClr;

	always_comb begin
		cicStb = (rateCnt >= effRate - RATE_W'(1));
		hb1OutStb = cicStb && hbPhase[0];
		pairStb = cicStb && (hbPhase == 2'b11);
		wordStb = interpDacMode ? pairStb : hb1OutStb;
		wordReq = wordStb;
		cicClr = cicOff || (effRate != prevRate);
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rateCnt <= '0;
		end else if (cicStb) begin
			rateCnt <= '0;
		end else begin
			rateCnt <= rateCnt + RATE_W'(1);
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			hbPhase <= '0;
		end else if (cicStb) begin
			hbPhase <= hbPhase + 2'b01;
		end
	end

	// a rate change restarts the CIC so stale integrator gain cannot linger
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			prevRate <= '0;
		end else begin
			prevRate <= effRate;
		end
	end

	//--------------------------------
	// input assembler
	//--------------------------------
	iqm_asm_t asmState;
	iqm_smp_t wordExt;
	iqm_smp_t iHold;
	iqm_smp_t pairSmp [2];

	assign wordExt = `IQM_DW'(signed'(dataWord));

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			asmState <= IQM_ASM_FLUSH;
			iHold <= '0;
			pairSmp[0] <= '0;
			pairSmp[1] <= '0;
		end else if (wordStb) begin
			case (asmState)
				IQM_ASM_FLUSH: begin
					pairSmp[0] <= '0;
					pairSmp[1] <= '0;
					if (txEnable) begin
						asmState <= IQM_ASM_WANT_I;
					end
				end
				IQM_ASM_WANT_I: begin
					if (!txEnable) begin
						asmState <= IQM_ASM_FLUSH;
					end else if (interpDacMode) begin
						pairSmp[0] <= wordExt;
						pairSmp[1] <= '0;
					end else begin
						iHold <= wordExt;
						asmState <= IQM_ASM_WANT_Q;
					end
				end
				IQM_ASM_WANT_Q: begin
					if (!txEnable) begin
						asmState <= IQM_ASM_FLUSH;
					end else begin
						pairSmp[0] <= iHold;
						pairSmp[1] <= wordExt;
						asmState <= IQM_ASM_WANT_I;
					end
				end
				default: begin
					asmState <= IQM_ASM_FLUSH;
				end
			endcase
		end
	end

	//--------------------------------
	// per-path chain: compensator, half-bands, CIC
	//--------------------------------
	iqm_smp_t cicOut [2];

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : gPath
			iqm_smp_t icTap [3];
			iqm_smp_t icOut;
			iqm_smp_t hb1Out;
			iqm_smp_t hb2Out;
			logic signed [`IQM_SAT_W-1:0] icSum;
			logic signed [ACC_W-1:0] comb [`IQM_CIC_ORDER+1];
			logic signed [ACC_W-1:0] combDly [`IQM_CIC_ORDER];
			logic signed [ACC_W-1:0] integ [`IQM_CIC_ORDER];

			// compensator taps stay frozen while bypassed
			always_ff @(posedge mclk or posedge sys_rst) begin
				if (sys_rst) begin
					for (int k = 0; k < 3; k++) begin
						icTap[k] <= '0;
					end
				end else if (pairStb && !icicOff) begin
					icTap[0] <= pairSmp[p];
					icTap[1] <= icTap[0];
					icTap[2] <= icTap[1];
				end
			end

			// symmetric 3-tap droop inverse, gain set by rate class
			always_comb begin
				if (effRate == `IQM_RATE_MIN) begin
					icSum = `IQM_SAT_W'(`IQM_ICIC_C_R2) * `IQM_SAT_W'(icTap[1]) -
						`IQM_SAT_W'(`IQM_ICIC_S_R2) *
						(`IQM_SAT_W'(icTap[0]) + `IQM_SAT_W'(icTap[2]));
				end else begin
					icSum = `IQM_SAT_W'(`IQM_ICIC_C_RN) * `IQM_SAT_W'(icTap[1]) -
						`IQM_SAT_W'(`IQM_ICIC_S_RN) *
						(`IQM_SAT_W'(icTap[0]) + `IQM_SAT_W'(icTap[2]));
				end
				icOut = icicOff ? pairSmp[p] : iqm_sat(icSum >>> `IQM_ICIC_SH);
			end

			iqm_halfband uHb1 (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.inStb(pairStb),
				.outStb(hb1OutStb),
				.din(icOut),
				.dout(hb1Out)
			);

			iqm_halfband uHb2 (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.inStb(hb1OutStb),
				.outStb(cicStb),
				.din(hb1Out),
				.dout(hb2Out)
			);

			// comb sections at the CIC input rate
			assign comb[0] = ACC_W'(hb2Out);
			for (genvar s = 0; s < `IQM_CIC_ORDER; s++) begin : gComb
				assign comb[s+1] = comb[s] - combDly[s];
				always_ff @(posedge mclk or posedge sys_rst) begin
					if (sys_rst) begin
						combDly[s] <= '0;
					end else if (cicClr) begin
						combDly[s] <= '0;
					end else if (cicStb) begin
						combDly[s] <= comb[s];
					end
				end
			end

			// integrators at the system clock, zero-stuffed input
			for (genvar s = 0; s < `IQM_CIC_ORDER; s++) begin : gInteg
				logic signed [ACC_W-1:0] feed;
				if (s == 0) begin : gFirst
					assign feed = cicStb ? comb[`IQM_CIC_ORDER] : '0;
				end else begin : gNext
					assign feed = integ[s-1];
				end
				always_ff @(posedge mclk or posedge sys_rst) begin
					if (sys_rst) begin
						integ[s] <= '0;
					end else if (cicClr) begin
						integ[s] <= '0;
					end else begin
						integ[s] <= integ[s] + feed;
					end
				end
			end

			always_comb begin
				if (cicOff) begin
					cicOut[p] = hb2Out;
				end else begin
					cicOut[p] = iqm_sat(`IQM_SAT_W'(integ[`IQM_CIC_ORDER-1] >>> cicShift));
				end
			end
		end
	endgenerate

	//--------------------------------
	// carrier synthesizer
	//--------------------------------
	logic [FTW_W-1:0] phaseAcc;
	logic [`IQM_PH_W-1:0] phTop;
	logic signed [`IQM_PH_W-1:0] carSin;
	logic signed [`IQM_PH_W-1:0] carCos;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			phaseAcc <= '0;
		end else if (interpDacMode) begin
			phaseAcc <= '0;
		end else begin
			phaseAcc <= phaseAcc + freqWord;
		end
	end

	always_comb begin
		phTop = phaseAcc[FTW_W-1 -: `IQM_PH_W];
		carSin = sineOf(phTop);
		carCos = sineOf(phTop + `IQM_PH_W'(1 << (`IQM_PH_W-2)));
	end

	//--------------------------------
	// quadrature modulator
	//--------------------------------
	logic signed [`IQM_SAT_W-1:0] prodI;
	logic signed [`IQM_SAT_W-1:0] prodQ;
	logic signed [`IQM_SAT_W-1:0] modSum;
	logic signed [`IQM_SAT_W-1:0] modRnd;
	logic signed [`IQM_SAT_W-1:0] outLim;
	logic signed [`IQM_SAT_W-1:0] outVal;

	always_comb begin
		prodI = `IQM_SAT_W'(cicOut[0]) * `IQM_SAT_W'(carCos);
		prodQ = `IQM_SAT_W'(cicOut[1]) * `IQM_SAT_W'(carSin);
		modSum = specInv ? prodI + prodQ : prodI - prodQ;
		modRnd = (modSum + (`IQM_SAT_W'(1) <<< (`IQM_MOD_SH - 1))) >>> `IQM_MOD_SH;
		outVal = interpDacMode ? `IQM_SAT_W'(cicOut[0]) : modRnd;
		outLim = (`IQM_SAT_W'(1) <<< (IN_W - 1)) - `IQM_SAT_W'(1);
		if (outVal > outLim) begin
			outVal = outLim;
		end else if (outVal < -outLim - `IQM_SAT_W'(1)) begin
			outVal = -outLim - `IQM_SAT_W'(1);
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			modOut <= '0;
		end else begin
			modOut <= IN_W'(outVal);
		end
	end

endmodule : iqm_interp_mod

`default_nettype wire

// ---- verification/iqm_interp_mod_props.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----
// port checker
// ----
module iqm_interp_mod_props #(
	parameter int IN_W = 14,
	parameter int RATE_W = 6
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// stream
	input wire logic txEnable,
	input wire logic wordReq,
	input wire logic [IN_W-1:0] modOut,
	// control
	input wire logic interpDacMode,
	input wire logic [1:0] profileSel,
	input wire logic [3:0][RATE_W-1:0] profCicRate,
	input wire logic [3:0] profCicBypass
);
	logic [6:0] effR;
	logic [8:0] cnt;
	logic [1:0] clean;
	logic [11:0] lowCnt;
	logic [RATE_W+3:0] cfg;
	logic [RATE_W+3:0] cfgOld;
	logic [1:0] steady;
	assign cfg = {interpDacMode, profileSel, profCicRate[profileSel], profCicBypass[profileSel]};
	// the cycle that shows a new configuration is not yet counted as settled
	assign steady = (cfg == cfgOld) ? clean : 2'h0;
	assign effR = profCicBypass[profileSel] ? 7'h01 :
		(profCicRate[profileSel] < 2) ? 7'h02 : 7'(profCicRate[profileSel]);
	// clean counts requests since the last configuration change
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 9'h000;
			clean <= 2'h0;
			cfgOld <= '0;
			lowCnt <= 12'h000;
		end else begin
			cfgOld <= cfg;
			cnt <= wordReq ? 9'h000 : cnt + 9'h001;
			lowCnt <= txEnable ? 12'h000 : (lowCnt == 12'h800) ? lowCnt : lowCnt + 12'h001;
			if (cfg != cfgOld) begin
				clean <= 2'h0;
			end else if (wordReq && clean != 2'h3) begin
				clean <= clean + 2'h1;
			end
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	AST_RST_ZERO: assert property (disable iff (1'b0) sys_rst |-> modOut == '0)
		else $error("output not cleared in reset");
	AST_REQ_PULSE: assert property (wordReq |=> !wordReq)
		else $error("word request longer than one cycle");
	AST_REQ_GAP_INTERP: assert property (steady[1] && interpDacMode && wordReq |=> !wordReq [*3])
		else $error("word requests too close in single path mode");
	AST_PERIOD_QUAD: assert property (wordReq && steady[1] && !interpDacMode |-> cnt == 9'(2 * effR - 1))
		else $error("pair request spacing wrong");
	AST_PERIOD_INTERP: assert property (wordReq && steady[1] && interpDacMode |-> cnt == 9'(4 * effR - 1))
		else $error("single path request spacing wrong");
	AST_REQ_WITHIN: assert property ($fell(wordReq) |-> ##[1:503] wordReq)
		else $error("word requests stopped");
	AST_FIRST_REQ: assert property ($fell(sys_rst) |-> ##[0:600] wordReq)
		else $error("no request after reset");
	AST_FLUSH_ZERO: assert property (lowCnt == 12'h800 && effR < 7'h09 |-> modOut == '0)
		else $error("flushed path not zero");
	COV_INTERP: cover property (interpDacMode && wordReq && steady[1]);
	COV_QUAD: cover property (!interpDacMode && wordReq && steady[1]);
	COV_FLUSH: cover property (lowCnt == 12'h800);
endmodule : iqm_interp_mod_props

bind iqm_interp_mod iqm_interp_mod_props #(.IN_W(IN_W), .RATE_W(RATE_W)) props (
	.mclk, .sys_rst, .txEnable, .wordReq, .modOut,
	.interpDacMode, .profileSel, .profCicRate, .profCicBypass
);
`default_nettype wire

// ---- verification/iqm_bb_source.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----
// baseband word source
// ----
module iqm_bb_source #(
	parameter int IN_W = 14
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// handshake
	input wire logic wordReq,
	input wire logic txEnable,
	input wire logic interpDacMode,
	// values to send
	input wire logic [IN_W-1:0] iVal,
	input wire logic [IN_W-1:0] qVal,
	output logic [IN_W-1:0] dataWord
);
	logic [1:0] slot;
	logic [IN_W-1:0] word;
	// 0 flush take due, 1 I next, 2 Q next
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			slot <= 2'h0;
		end else if (wordReq) begin
			slot <= !txEnable ? 2'h0 : interpDacMode ? 2'h1 : (slot == 2'h1) ? 2'h2 : 2'h1;
		end
	end
	assign word = (slot == 2'h2) ? qVal : iVal;
	// outside a take the bus shows the inverse so a late sample is caught
	assign dataWord = wordReq ? word : ~word;
endmodule : iqm_bb_source
`default_nettype wire

// ---- verification/iqm_interp_mod_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "iqm_params.svh"
// ----
// testbench
// ----
module iqm_interp_mod_tb;
	logic mclk = 1'b0;
	logic sys_rst = 1'b0;
	logic txEnable = 1'b0;
	logic interpDacMode = 1'b1;
	logic invCicBypass = 1'b1;
	logic [1:0] profileSel = 2'h0;
	logic [3:0][5:0] profCicRate = {6'h00, 6'h02, 6'h04, 6'h02};
	logic [3:0] profCicBypass = 4'h4;
	logic [3:0] profSpecInvert = 4'h5;
	logic [3:0][31:0] profFreqWord = {32'h2000_0000, 32'h0000_0000, 32'h4000_0000, 32'h4000_0000};
	logic [13:0] iVal = 14'h0000;
	logic [13:0] qVal = 14'h0000;
	logic [13:0] dataWord;
	logic [13:0] modOut;
	logic wordReq;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;

	always #5 mclk = ~mclk;

	iqm_interp_mod dut (.mclk, .sys_rst, .dataWord, .txEnable, .wordReq, .interpDacMode,
		.invCicBypass, .profileSel, .profCicRate, .profCicBypass, .profSpecInvert,
		.profFreqWord, .modOut);
	iqm_bb_source src (.mclk, .sys_rst, .wordReq, .txEnable, .interpDacMode, .iVal, .qVal,
		.dataWord);

	task automatic conclude();
		$display("checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic signed [15:0] seen, input logic signed [15:0] exp,
		input int tol);
		comparisons++;
		if ($isunknown(seen) || seen - exp > tol || exp - seen > tol) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic setup(input logic [1:0] sel, input logic mode, input logic icb,
		input logic en, input logic [13:0] i, input logic [13:0] q, input int n);
		@(posedge mclk);
		profileSel <= sel;
		interpDacMode <= mode;
		invCicBypass <= icb;
		txEnable <= en;
		iVal <= i;
		qVal <= q;
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask : setup

	// single path: compensator off/on, rate 2 and 4, CIC bypass, rate 0
	task automatic scenInterp();
		setup(2'h0, 1'b1, 1'b1, 1'b1, 14'h0FA0, 14'h0000, 600);
		check($signed(modOut), 16'sh0FA0, 16);
		setup(2'h0, 1'b1, 1'b0, 1'b1, 14'h0FA0, 14'h0000, 600);
		check($signed(modOut), 16'(4000 * (`IQM_ICIC_C_R2 - 2 * `IQM_ICIC_S_R2) / 32), 16);
		setup(2'h1, 1'b1, 1'b0, 1'b1, 14'h0FA0, 14'h0000, 600);
		check($signed(modOut), 16'(4000 * (`IQM_ICIC_C_RN - 2 * `IQM_ICIC_S_RN) / 32), 16);
		setup(2'h2, 1'b1, 1'b0, 1'b1, 14'h0FA0, 14'h0000, 600);
		check($signed(modOut), 16'sh0FA0, 16);
		setup(2'h3, 1'b1, 1'b1, 1'b1, 14'h0FA0, 14'h0000, 600);
		check($signed(modOut), 16'sh0FA0, 16);
	endtask : scenInterp

	task automatic scenFlush();
		setup(2'h0, 1'b1, 1'b1, 1'b0, 14'h0FA0, 14'h0000, 2100);
		check($signed(modOut), 16'sh0000, 0);
	endtask : scenFlush

	// carrier in quarter turns: the sample after I*cos shows Q*sin, added or subtracted by spectral invert
	task automatic scenQuad(input logic [1:0] sel, input logic signed [15:0] nextExp);
		logic hit;
		hit = 1'b0;
		setup(sel, 1'b0, 1'b1, 1'b1, 14'h07D0, 14'h3C18, 600);
		for (int k = 0; k < 8 && !hit; k++) begin
			hit = $signed(modOut) > 14'sh0780;
			@(negedge mclk);
		end
		check(16'(hit), 16'h0001, 0);
		check($signed(modOut), nextExp, 16);
	endtask : scenQuad

	task automatic scenSat();
		logic hit;
		hit = 1'b0;
		setup(2'h3, 1'b0, 1'b1, 1'b1, 14'h1FFF, 14'h2000, 600);
		repeat (8) begin
			hit |= (modOut === 14'h1FFF);
			@(negedge mclk);
		end
		check(16'(hit), 16'h0001, 0);
	endtask : scenSat

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	initial begin
		// a real edge on reset clears the design before the first clock edge
		sys_rst <= 1'b1;
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (2100) @(posedge mclk);
		scenInterp();
		scenFlush();
		scenQuad(2'h0, -16'sh03E8);
		scenQuad(2'h1, 16'sh03E8);
		scenSat();
		conclude();
	end
endmodule : iqm_interp_mod_tb
`default_nettype wire
